//--- swfc_bank.sv
// Stop window, timeout and fire configuration bank with Avalon-MM slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module swfc_bank
    import swfc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic mode2_i,
    input wire logic calc_strobe_i,
    input wire logic timeout_i,
    input wire logic [2:0] hit_enable_i,
    input wire logic [95:0] hit_results_i,
    output logic [31:0] result4_o,
    output logic result4_valid_o,
    output logic mode2_auto_sum_enable_o,
    output logic timeout_error_value_enable_o,
    output logic first_wave_enable_o,
    output logic [12:0] timeout_us_o,
    output logic [5:0] rel_delay_stop_one_o,
    output logic [5:0] rel_delay_stop_two_o,
    output logic [5:0] rel_delay_stop_three_o,
    output logic [18:0] stop_enable_delay_hit_two_o,
    output logic [18:0] stop_enable_delay_hit_three_o,
    output logic pulse_width_meas_enable_o,
    output logic first_wave_falling_o,
    output logic [6:0] comparator_offset_mv_o,
    output logic fire_up_enable_o,
    output logic fire_down_enable_o,
    output logic fire_down_invert_o,
    output logic start_noise_on_o,
    output logic phase_noise_run_o,
    output logic [3:0] fire_sequence_count_o,
    output logic [14:0] pulse_phase_invert_mask_o
);
    swfc_state_s st_q;
    swfc_state_s st_d;
    logic [6:0] dec_mv;
    logic [5:0] idx;

    assign idx = avs_address_i[7:2];

    swfc_offset_decode u_comparator_offset_code (
        .code_i(st_q.hit3_reg[SWFC_B_COMPARATOR_OFFSET_CODE +: 5]),
        .plus_i(st_q.hit3_reg[SWFC_B_RNGP]),
        .minus_i(st_q.hit3_reg[SWFC_B_RNGM]),
        .mv_o(dec_mv)
    );

    function automatic logic [31:0] swfc_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] stat;
        logic [31:0] sum;
        logic fw;
        logic [5:0] r1;
        logic [5:0] r2;
        logic [5:0] r3;
        stat = 32'h0000_0000;
        sum = 32'h0000_0000;
        st_d = st_q;
        st_d.waitreq = 1'b1;
        fw = st_q.stop_reg[SWFC_B_FWAVE];
        r1 = st_q.stop_reg[SWFC_B_DREL1 +: 6];
        r2 = st_q.stop_reg[SWFC_B_DREL2 +: 6];
        r3 = st_q.stop_reg[SWFC_B_DREL3 +: 6];
        // Status word flags software settings the hardware cannot honour
        stat[0] = (st_q.fire_reg[SWFC_B_FDOWN +: 3] == SWFC_FIRE_BAD); // R16
        stat[1] = st_q.fire_reg[SWFC_B_RSVD23]; // R22
        stat[2] = fw && (r1 < SWFC_DREL1_MIN); // R05
        stat[3] = fw && ((r2 < SWFC_DREL2_MIN) || (r2 <= r1)); // R06
        stat[4] = fw && ((r3 < SWFC_DREL3_MIN) || (r3 <= r2)); // R07
        stat[5] = fw && (st_q.hit3_reg[SWFC_B_TOP5 +: 5]
            != SWFC_HIT3_TOP_DEF); // R15
        stat[6] = fw;
        stat[14:8] = st_q.offset_mv;
        stat[15] = st_q.result4_valid;

        // Bus: one idle cycle latches the answer, then one acknowledge cycle
        case (st_q.bus)
            SWFC_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_d.bus = SWFC_BUS_ACK;
                    st_d.waitreq = 1'b0;
                    if (avs_read_i) begin
                        if (idx == SWFC_IDX_STOP) begin
                            st_d.rdata = st_q.stop_reg; // R23
                        end else if (idx == SWFC_IDX_HIT3) begin
                            st_d.rdata = st_q.hit3_reg; // R23
                        end else if (idx == SWFC_IDX_FIRE) begin
                            st_d.rdata = st_q.fire_reg; // R23
                        end else if (idx == SWFC_IDX_STAT) begin
                            st_d.rdata = stat;
                        end else begin
                            st_d.rdata = 32'h0000_0000;
                        end
                    end
                end
            end
            SWFC_BUS_ACK: begin
                st_d.bus = SWFC_BUS_IDLE;
                // Writes land at the edge where waitrequest is seen low
                if (avs_write_i) begin
                    if (idx == SWFC_IDX_STOP) begin
                        st_d.stop_reg = swfc_merge(st_q.stop_reg,
                            avs_writedata_i, avs_byteenable_i);
                    end else if (idx == SWFC_IDX_HIT3) begin
                        st_d.hit3_reg = swfc_merge(st_q.hit3_reg,
                            avs_writedata_i, avs_byteenable_i);
                    end else if (idx == SWFC_IDX_FIRE) begin
                        st_d.fire_reg = swfc_merge(st_q.fire_reg,
                            avs_writedata_i, avs_byteenable_i);
                    end
                end
            end
            default: begin
                st_d.bus = SWFC_BUS_IDLE;
            end
        endcase

        // Result four: timeout code wins over the auto sum
        st_d.result4_valid = 1'b0;
        for (int h = 0; h < 3; h++) begin
            if (hit_enable_i[h]) begin
                sum = 32'(sum + hit_results_i[32*h +: 32]); // R01
            end
        end
        if (calc_strobe_i) begin
            if (timeout_i && st_q.err_val_en) begin
                st_d.result4 = SWFC_TIMEOUT_CODE; // R02
                st_d.result4_valid = 1'b1;
            end else if (mode2_i && st_q.auto_sum_en) begin
                st_d.result4 = sum; // R01
                st_d.result4_valid = 1'b1;
            end
        end

        // Decoded view, one cycle behind the stored registers
        st_d.auto_sum_en = st_q.stop_reg[SWFC_B_AUTOSUM]; // R01
        st_d.err_val_en = st_q.stop_reg[SWFC_B_ERRVAL]; // R02
        st_d.first_wave = fw; // R03
        case (st_q.stop_reg[SWFC_B_TIMO +: 2])
            2'h0: st_d.timeout_us = SWFC_TIMO_US_0; // R04
            2'h1: st_d.timeout_us = SWFC_TIMO_US_1; // R04
            2'h2: st_d.timeout_us = SWFC_TIMO_US_2; // R04
            default: st_d.timeout_us = SWFC_TIMO_US_3; // R04
        endcase
        // Same bits mean relative stops or absolute delay, never both
        st_d.drel1 = fw ? r1 : 6'h00; // R03
        st_d.drel2 = fw ? r2 : 6'h00; // R03
        st_d.drel3 = fw ? r3 : 6'h00; // R03
        st_d.dval2 = fw ? 19'h00000
            : st_q.stop_reg[SWFC_B_DVAL +: 19]; // R08
        st_d.dval3 = fw ? 19'h00000
            : st_q.hit3_reg[SWFC_B_DVAL +: 19]; // R10
        // Comparator settings only apply in first-wave mode
        st_d.pw_enable = fw && !st_q.hit3_reg[SWFC_B_DISPW]; // R11
        st_d.fw_falling = fw && st_q.hit3_reg[SWFC_B_EDGE]; // R12
        st_d.offset_mv = fw ? dec_mv : 7'h00; // R13 R14
        st_d.fire_up = st_q.fire_reg[SWFC_B_FUP]; // R17
        st_d.fire_down = st_q.fire_reg[SWFC_B_FDOWN]; // R17
        st_d.fire_inv = st_q.fire_reg[SWFC_B_FBOTH]; // R17
        st_d.noise_on = st_q.fire_reg[SWFC_B_SNOISE]; // R18
        st_d.phase_run = !st_q.fire_reg[SWFC_B_DISPH]; // R19
        st_d.seq_count = {1'b0, st_q.fire_reg[SWFC_B_REPEAT +: 3]}
            + 4'h1; // R20
        st_d.phase_mask = st_q.fire_reg[SWFC_B_PHASE +: 15]; // R21
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            st_q.bus <= SWFC_BUS_IDLE;
            st_q.waitreq <= 1'b1;
            st_q.stop_reg <= SWFC_RST_STOP;
            st_q.hit3_reg <= SWFC_RST_HIT3;
            st_q.fire_reg <= SWFC_RST_FIRE;
            st_q.timeout_us <= SWFC_TIMO_US_0;
            st_q.phase_run <= 1'b1;
            st_q.seq_count <= 4'h1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata_o = st_q.rdata;
    assign avs_waitrequest_o = st_q.waitreq;
    assign result4_o = st_q.result4;
    assign result4_valid_o = st_q.result4_valid;
    assign mode2_auto_sum_enable_o = st_q.auto_sum_en;
    assign timeout_error_value_enable_o = st_q.err_val_en;
    assign first_wave_enable_o = st_q.first_wave;
    assign timeout_us_o = st_q.timeout_us;
    assign rel_delay_stop_one_o = st_q.drel1;
    assign rel_delay_stop_two_o = st_q.drel2;
    assign rel_delay_stop_three_o = st_q.drel3;
    assign stop_enable_delay_hit_two_o = st_q.dval2;
    assign stop_enable_delay_hit_three_o = st_q.dval3;
    assign pulse_width_meas_enable_o = st_q.pw_enable;
    assign first_wave_falling_o = st_q.fw_falling;
    assign comparator_offset_mv_o = st_q.offset_mv;
    assign fire_up_enable_o = st_q.fire_up;
    assign fire_down_enable_o = st_q.fire_down;
    assign fire_down_invert_o = st_q.fire_inv;
    assign start_noise_on_o = st_q.noise_on;
    assign phase_noise_run_o = st_q.phase_run;
    assign fire_sequence_count_o = st_q.seq_count;
    assign pulse_phase_invert_mask_o = st_q.phase_mask;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    bus_ack_a: assert property ((avs_read_i || avs_write_i)
        && st_q.bus == SWFC_BUS_IDLE
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("Bus acknowledge not one cycle");

    fire_write_a: assert property (st_q.bus == SWFC_BUS_ACK && avs_write_i
        && idx == SWFC_IDX_FIRE && avs_byteenable_i == 4'hf
        |=> st_q.fire_reg == $past(avs_writedata_i)) // R23
        else $error("Fire register write lost");

    auto_sum_a: assert property (calc_strobe_i && mode2_i
        && st_q.auto_sum_en && !timeout_i && hit_enable_i == 3'h7
        |=> result4_valid_o && result4_o == 32'($past(hit_results_i[31:0])
        + $past(hit_results_i[63:32]) + $past(hit_results_i[95:64])))
        else $error("Auto sum result wrong"); // R01

    err_value_a: assert property (calc_strobe_i && timeout_i
        && st_q.err_val_en
        |=> result4_valid_o && result4_o == 32'h0fff_ffff)
        else $error("Timeout code not written"); // R02

    first_wave_a: assert property (!st_q.stop_reg[SWFC_B_FWAVE]
        |=> rel_delay_stop_one_o == 6'h00 && !pulse_width_meas_enable_o
        && stop_enable_delay_hit_two_o
        == $past(st_q.stop_reg[SWFC_B_DVAL +: 19]))
        else $error("First-wave reinterpretation wrong"); // R03 R08

    timeout_sel_a: assert property (st_q.stop_reg[SWFC_B_TIMO +: 2] == 2'h2
        |=> timeout_us_o == 13'd1024)
        else $error("Timeout predivider decode wrong"); // R04

    hit3_delay_a: assert property (!st_q.stop_reg[SWFC_B_FWAVE]
        |=> stop_enable_delay_hit_three_o
        == $past(st_q.hit3_reg[SWFC_B_DVAL +: 19]))
        else $error("Hit three delay wrong"); // R10

    comp_edge_a: assert property (st_q.stop_reg[SWFC_B_FWAVE]
        |=> first_wave_falling_o == $past(st_q.hit3_reg[SWFC_B_EDGE])
        && pulse_width_meas_enable_o
        == !$past(st_q.hit3_reg[SWFC_B_DISPW]))
        else $error("Edge or pulse width decode wrong"); // R11 R12

    offset_mv_a: assert property (st_q.stop_reg[SWFC_B_FWAVE]
        && st_q.hit3_reg[SWFC_B_COMPARATOR_OFFSET_CODE +: 5] == 5'h1f
        && st_q.hit3_reg[SWFC_B_RNGP] && !st_q.hit3_reg[SWFC_B_RNGM]
        |=> comparator_offset_mv_o == 7'h13)
        else $error("Comparator offset decode wrong"); // R13 R14

    fire_out_a: assert property (1'b1 |=> fire_down_invert_o
        == $past(st_q.fire_reg[31]) && fire_up_enable_o
        == $past(st_q.fire_reg[30]) && fire_down_enable_o
        == $past(st_q.fire_reg[29]))
        else $error("Fire output enables wrong"); // R17

    noise_a: assert property (1'b1 |=> start_noise_on_o
        == $past(st_q.fire_reg[28]) && phase_noise_run_o
        == !$past(st_q.fire_reg[27]))
        else $error("Noise unit control wrong"); // R18 R19

    repeat_a: assert property (st_q.fire_reg[26:24] == 3'h7
        |=> fire_sequence_count_o == 4'h8)
        else $error("Repeat count wrong"); // R20

    phase_mask_a: assert property (1'b1 |=> pulse_phase_invert_mask_o
        == $past(st_q.fire_reg[22:8]))
        else $error("Phase mask wrong"); // R21
endmodule
`default_nettype wire

//--- swfc_offset_decode.sv
// Comparator offset decoder: signed code plus range shifts to millivolts
`timescale 1ns/100ps
`default_nettype none
module swfc_offset_decode
    import swfc_pkg::*;
(
    input wire logic [4:0] code_i,
    input wire logic plus_i,
    input wire logic minus_i,
    output logic [6:0] mv_o
);
    logic [6:0] base;
    logic [6:0] plus;
    logic [6:0] minus;

    always_comb begin
        base = {{2{code_i[4]}}, code_i}; // R13
        plus = plus_i ? SWFC_RANGE_MV : 7'h00; // R14
        minus = minus_i ? SWFC_RANGE_MV : 7'h00; // R14
        // Range -36..+35 mV always fits seven signed bits
        mv_o = 7'(base + plus - minus);
    end
endmodule
`default_nettype wire

//--- swfc_pkg.sv
// Constants and types for the stop window and fire configuration bank
// How it works
// R01: In mode 2 with auto-sum on, enabled hit results are summed into result four.
// R02: With error value on, a timeout writes the all-ones code as result; the bank writes 0fff_ffff instead.
// R03: First-wave enable turns on first-hit detection and reinterprets registers three, four.
// R04: Mode-2 timeout predivider codes 0..3 give 64, 256, 1024, 4096 us.
// R05: Software keeps the first-stop relative delay within 3 to 63.
// R06: Software keeps second-stop delay within 4 to 63, above the first.
// R07: Software keeps third-stop delay within 5 to 63, above the second.
// R08: Hit-two stop-enable delay is unsigned 14.5 fixed point in reference periods.
// R09: Software zeroes hit-two and hit-three delays while the analog front end is off.
// R10: Hit-three stop-enable delay uses the same 19-bit fixed-point format.
// R11: Pulse-width measurement runs while its disable bit is zero.
// R12: First-wave edge bit selects rising edge at zero, falling at one.
// R13: Five-bit comparator offset is two's complement in 1 mV steps.
// R14: Two range bits add +20 mV and -20 mV shifts independently.
// R15: Software keeps the top five bits of register four at default.
// R16: Software never loads the fire output configuration with pattern 011.
// R17: Bit 30 enables up output, 29 down output, 31 inverts down output.
// R18: Start-noise bit switches on the start channel noise unit.
// R19: Phase-noise unit runs while its disable bit is zero.
// R20: Repeat field repeats the fire sequence 0 to 7 extra times.
// R21: Each phase bit selects inversion for one of up to 15 pulses.
// R22: Software always writes zero to bit 23 of the fire configuration.
// R23: Free low-byte bits are stored, read back and otherwise ignored.
package swfc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] SWFC_IDX_STOP = 6'h03;
    localparam logic [5:0] SWFC_IDX_HIT3 = 6'h04;
    localparam logic [5:0] SWFC_IDX_FIRE = 6'h05;
    localparam logic [5:0] SWFC_IDX_STAT = 6'h08;
    // Reset values
    localparam logic [31:0] SWFC_RST_STOP = 32'h0000_0000;
    localparam logic [31:0] SWFC_RST_HIT3 = 32'h2000_0000;
    localparam logic [31:0] SWFC_RST_FIRE = 32'h0000_0000;
    localparam logic [4:0] SWFC_HIT3_TOP_DEF = 5'h04;
    localparam logic [31:0] SWFC_TIMEOUT_CODE = 32'h0fff_ffff;
    // Stop/timeout register fields
    localparam int SWFC_B_AUTOSUM = 31;
    localparam int SWFC_B_FWAVE = 30;
    localparam int SWFC_B_ERRVAL = 29;
    localparam int SWFC_B_TIMO = 27;
    localparam int SWFC_B_DREL3 = 21;
    localparam int SWFC_B_DREL2 = 15;
    localparam int SWFC_B_DREL1 = 9;
    localparam int SWFC_B_DVAL = 8;
    // Hit-three/offset register fields
    localparam int SWFC_B_TOP5 = 27;
    localparam int SWFC_B_DISPW = 17;
    localparam int SWFC_B_EDGE = 16;
    localparam int SWFC_B_RNGP = 15;
    localparam int SWFC_B_RNGM = 14;
    localparam int SWFC_B_COMPARATOR_OFFSET_CODE = 8;
    // Fire register fields
    localparam int SWFC_B_FBOTH = 31;
    localparam int SWFC_B_FUP = 30;
    localparam int SWFC_B_FDOWN = 29;
    localparam int SWFC_B_SNOISE = 28;
    localparam int SWFC_B_DISPH = 27;
    localparam int SWFC_B_REPEAT = 24;
    localparam int SWFC_B_RSVD23 = 23;
    localparam int SWFC_B_PHASE = 8;
    // Limits of the relative stop delays
    localparam logic [5:0] SWFC_DREL1_MIN = 6'h03;
    localparam logic [5:0] SWFC_DREL2_MIN = 6'h04;
    localparam logic [5:0] SWFC_DREL3_MIN = 6'h05;
    localparam logic [2:0] SWFC_FIRE_BAD = 3'h3;
    // Mode-2 timeout per predivider code, in microseconds
    localparam logic [12:0] SWFC_TIMO_US_0 = 13'h0040;
    localparam logic [12:0] SWFC_TIMO_US_1 = 13'h0100;
    localparam logic [12:0] SWFC_TIMO_US_2 = 13'h0400;
    localparam logic [12:0] SWFC_TIMO_US_3 = 13'h1000;
    localparam logic [6:0] SWFC_RANGE_MV = 7'h14;

    typedef enum logic [1:0] {
        SWFC_BUS_IDLE = 2'b01,
        SWFC_BUS_ACK = 2'b10
    } swfc_bus_e;

    typedef struct packed {
        swfc_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [31:0] stop_reg;
        logic [31:0] hit3_reg;
        logic [31:0] fire_reg;
        logic [31:0] result4;
        logic result4_valid;
        logic auto_sum_en;
        logic err_val_en;
        logic first_wave;
        logic [12:0] timeout_us;
        logic [5:0] drel1;
        logic [5:0] drel2;
        logic [5:0] drel3;
        logic [18:0] dval2;
        logic [18:0] dval3;
        logic pw_enable;
        logic fw_falling;
        logic [6:0] offset_mv;
        logic fire_up;
        logic fire_down;
        logic fire_inv;
        logic noise_on;
        logic phase_run;
        logic [3:0] seq_count;
        logic [14:0] phase_mask;
    } swfc_state_s;
endpackage

//--- tb_swfc_bank.sv
// Self-checking bench for the stop window and fire configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb_swfc_bank
    import swfc_pkg::*;
;
    logic ref_clk, rst_n, rd, wr, wreq, strobe, tmo, mode2, r4v;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, r4, d, h, f, r;
    logic [3:0] be;
    logic [2:0] hen;
    logic [95:0] hres;
    logic o_sum, o_err, o_fw, o_pw, o_fall, o_up, o_dn, o_inv, o_sn, o_ph;
    logic [12:0] o_timo;
    logic [5:0] o_d1, o_d2, o_d3, a1, a2, a3;
    logic [18:0] o_v2, o_v3;
    logic [6:0] o_mv;
    logic [3:0] o_cnt;
    logic [14:0] o_mask;
    int n_errors = 0;
    int n_checks = 0;

    swfc_bank dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .mode2_i(mode2), .calc_strobe_i(strobe), .timeout_i(tmo),
        .hit_enable_i(hen), .hit_results_i(hres), .result4_o(r4),
        .result4_valid_o(r4v), .mode2_auto_sum_enable_o(o_sum),
        .timeout_error_value_enable_o(o_err), .first_wave_enable_o(o_fw),
        .timeout_us_o(o_timo), .rel_delay_stop_one_o(o_d1),
        .rel_delay_stop_two_o(o_d2), .rel_delay_stop_three_o(o_d3),
        .stop_enable_delay_hit_two_o(o_v2),
        .stop_enable_delay_hit_three_o(o_v3),
        .pulse_width_meas_enable_o(o_pw), .first_wave_falling_o(o_fall),
        .comparator_offset_mv_o(o_mv), .fire_up_enable_o(o_up),
        .fire_down_enable_o(o_dn), .fire_down_invert_o(o_inv),
        .start_noise_on_o(o_sn), .phase_noise_run_o(o_ph),
        .fire_sequence_count_o(o_cnt), .pulse_phase_invert_mask_o(o_mask));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [5:0] i,
                       input logic [31:0] dv, input logic [3:0] b,
                       output logic [31:0] q);
        int k;
        k = 0;
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        addr <= {i, 2'b00};
        wdata <= dv;
        be <= b;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            n_errors++;
            results();
        end
    endtask

    task automatic wreg(input logic [5:0] i, input logic [31:0] dv,
                        input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, i, dv, b, q);
    endtask

    task automatic creg(input logic [5:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, i, 32'h0, 4'h0, q);
        chk(q, e);
    endtask

    // Decoded outputs trail the write edge by one further edge
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [12:0] timo_exp(input logic [1:0] c);
        return 13'h0040 << (2 * c);
    endfunction

    function automatic logic [6:0] mv_exp(input logic [4:0] c,
                                          input logic p, input logic m);
        logic [6:0] v;
        v = {{2{c[4]}}, c};
        if (p) v = v + 7'h14;
        if (m) v = v - 7'h14;
        return v;
    endfunction

    task automatic calc(input logic t, input logic m2, input logic s,
                        input logic e);
        logic [2:0] hv;
        logic [95:0] rv;
        logic [31:0] x;
        hv = 3'($urandom);
        rv = {$urandom, $urandom, $urandom};
        x = 32'h0;
        for (int k = 0; k < 3; k++)
            if (hv[k]) x = x + rv[32*k +: 32];
        @(posedge ref_clk);
        tmo <= t;
        mode2 <= m2;
        hen <= hv;
        hres <= rv;
        strobe <= 1'b1;
        @(posedge ref_clk);
        strobe <= 1'b0;
        #1;
        chk(r4v, (t && e) || (m2 && s));
        if (t && e) chk(r4, 32'h0fff_ffff);
        else if (m2 && s) chk(r4, x);
        @(posedge ref_clk);
        #1;
        chk(r4v, 1'b0);
    endtask

    initial begin
        #2000000;
        n_errors++;
        results();
    end

    initial begin
        {rd, wr, strobe, tmo, mode2, addr, wdata, be, hen, hres} = '0;
        rst_n = 1'b0;
        void'($urandom(32'he53b));
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        creg(SWFC_IDX_STOP, SWFC_RST_STOP);
        creg(SWFC_IDX_HIT3, SWFC_RST_HIT3);
        creg(SWFC_IDX_FIRE, SWFC_RST_FIRE);
        chk(o_timo, 13'h0040);
        chk(o_ph, 1'b1);
        chk(o_cnt, 4'h1);
        for (int c = 0; c < 4; c++) begin
            d = $urandom & 32'hbfff_ffff;
            d[28:27] = c[1:0];
            h = {5'h04, 27'($urandom)};
            wreg(SWFC_IDX_STOP, d, 4'hf);
            wreg(SWFC_IDX_HIT3, h, 4'hf);
            settle();
            chk(o_timo, timo_exp(d[28:27]));
            chk(o_v2, d[26:8]);
            chk(o_v3, h[26:8]);
            chk(o_sum, d[31]);
            chk(o_err, d[29]);
            chk(o_fw, 1'b0);
            creg(SWFC_IDX_STOP, d);
            creg(SWFC_IDX_HIT3, h);
        end
        // Byte lanes and places with no register behind them
        wreg(SWFC_IDX_HIT3, 32'hffff_ffff, 4'h1);
        creg(SWFC_IDX_HIT3, {h[31:8], 8'hff});
        wreg(6'h0f, 32'h5a5a_5a5a, 4'hf);
        creg(6'h0f, 32'h0);
        creg(6'h02, 32'h0);
        // Front end off: software clears both stop-enable delays
        wreg(SWFC_IDX_STOP, 32'h0000_0000, 4'hf);
        wreg(SWFC_IDX_HIT3, SWFC_RST_HIT3, 4'hf);
        settle();
        chk(32'(o_v2), 32'h0);
        chk(32'(o_v3), 32'h0);
        for (int i = 0; i < 128; i++) begin
            r = $urandom;
            if (i == 0) r[11:0] = 12'h0;
            a1 = 6'h03 + r[3:0];
            a2 = a1 + 6'h01 + r[7:4];
            a3 = a2 + 6'h01 + r[11:8];
            d = {3'b010, 2'b00, a3, a2, a1, 1'b0, r[31:24]};
            h = {5'h04, 9'h0, r[12], r[13], i[5], i[6], 1'b0, i[4:0],
                 r[23:16]};
            wreg(SWFC_IDX_HIT3, h, 4'hf);
            wreg(SWFC_IDX_STOP, d, 4'hf);
            settle();
            chk(o_fw, 1'b1);
            chk({o_d3, o_d2, o_d1}, {a3, a2, a1});
            chk(32'(o_v2), 32'h0);
            chk(32'(o_v3), 32'h0);
            chk(o_pw, !r[12]);
            chk(o_fall, r[13]);
            chk(o_mv, mv_exp(i[4:0], i[5], i[6]));
        end
        creg(SWFC_IDX_HIT3, h);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            f = {(i == 3) ? 3'h4 : i[2:0], r[28:27], i[2:0], 1'b0,
                 r[22:0]};
            wreg(SWFC_IDX_FIRE, f, 4'hf);
            settle();
            chk({o_inv, o_up, o_dn}, f[31:29]);
            chk(o_sn, f[28]);
            chk(o_ph, !f[27]);
            chk(o_cnt, {1'b0, i[2:0]} + 4'h1);
            chk(o_mask, f[22:8]);
            creg(SWFC_IDX_FIRE, f);
        end
        // Forbidden fire pattern and bit 23 are flagged in the status word
        wreg(SWFC_IDX_FIRE, 32'h6080_0000, 4'hf);
        wreg(SWFC_IDX_STAT, 32'hffff_ffff, 4'hf);
        creg(SWFC_IDX_STAT, {16'h0, 1'b0, mv_exp(5'h1f, 1'b1, 1'b1),
                             8'h43});
        // Auto-sum and timeout code, then strobes that must be ignored
        wreg(SWFC_IDX_STOP, 32'ha000_0000, 4'hf);
        settle();
        calc(1'b0, 1'b1, 1'b1, 1'b1);
        calc(1'b1, 1'b1, 1'b1, 1'b1);
        calc(1'b1, 1'b0, 1'b1, 1'b1);
        calc(1'b0, 1'b0, 1'b1, 1'b1);
        wreg(SWFC_IDX_STOP, 32'h8000_0000, 4'hf);
        settle();
        calc(1'b1, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            calc(1'b0, 1'b1, 1'b1, 1'b0);
        end
        wreg(SWFC_IDX_STOP, 32'h0000_0000, 4'hf);
        settle();
        calc(1'b1, 1'b1, 1'b0, 1'b0);
        results();
    end
endmodule
`default_nettype wire
